// [design/swwd_top.sv]
// Overview of operation
// - Undervoltage drives reset output low.
// - Supply good starts delay, then releases reset.
// - Power-on reset held until supply good, delay.
// - Enable input low disables watchdog entirely.
// - Service ignored in reset, fault, disabled.
// - Window violation asserts watchdog fault output.
// - Fault held for reset delay, then released.
// - Fault asserts only while reset released.
// - Reset low releases fault output.
// - Manual reset low asserts, delay after release.
`timescale 1ns/1ps
module swwd_top #(
  parameter logic [31:0] RST_DELAY_CYC = swwd_pkg::RST_DELAY_CYC,
  parameter logic [31:0] WIN0_LOWER_CYC = swwd_pkg::WIN0_LOWER_CYC,
  parameter logic [31:0] WIN0_UPPER_CYC = swwd_pkg::WIN0_UPPER_CYC,
  parameter logic [31:0] WIN1_LOWER_CYC = swwd_pkg::WIN1_LOWER_CYC,
  parameter logic [31:0] WIN1_UPPER_CYC = swwd_pkg::WIN1_UPPER_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire swwd_pkg::swwd_pins_s pins,
  output logic reset_n,
  output logic reset_oe,
  output logic watchdog_fault_n,
  output logic watchdog_fault_oe
);
  import swwd_pkg::*;

  swwd_pins_s sync1_reg;
  swwd_pins_s sync2_reg;
  logic svc_prev_reg;
  swwd_rst_e rs_reg;
  swwd_rst_e rs_next;
  swwd_wd_e wd_reg;
  swwd_wd_e wd_next;
  logic [CNT_W-1:0] rs_cnt_reg;
  logic [CNT_W-1:0] rs_cnt_next;
  logic [CNT_W-1:0] wd_cnt_reg;
  logic [CNT_W-1:0] wd_cnt_next;

  // Input synchronisers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync1_reg <= PINS_RST;
      sync2_reg <= PINS_RST;
      svc_prev_reg <= PINS_RST.watchdog_service_in;
    end else begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
      svc_prev_reg <= sync2_reg.watchdog_service_in;
    end
  end

  // Decode
  wire hold_w = sync2_reg.undervoltage_in | ~sync2_reg.manual_reset_n;
  wire en_w = sync2_reg.watchdog_enable_in;
  wire edge_w = svc_prev_reg & ~sync2_reg.watchdog_service_in;
  wire [CNT_W-1:0] lower_w =
    sync2_reg.timeout_select_in ? WIN1_LOWER_CYC : WIN0_LOWER_CYC;
  wire [CNT_W-1:0] upper_w =
    sync2_reg.timeout_select_in ? WIN1_UPPER_CYC : WIN0_UPPER_CYC;
  wire rs_done_w = (rs_cnt_reg == RST_DELAY_CYC - CNT_ONE);
  wire wd_done_w = (wd_cnt_reg == RST_DELAY_CYC - CNT_ONE);
  wire early_w = (wd_cnt_reg < lower_w);
  wire late_w = (wd_cnt_reg == upper_w - CNT_ONE);
  wire run_w = (rs_next == SWWD_RS_RUN);

  // Reset supervisor
  always_comb begin
    rs_next = rs_reg;
    rs_cnt_next = rs_cnt_reg;
    case (rs_reg)
      SWWD_RS_ASSERT: begin
        rs_cnt_next = CNT_ZERO;
        if (!hold_w) begin
          rs_next = SWWD_RS_DELAY;
        end
      end
      SWWD_RS_DELAY: begin
        rs_cnt_next = rs_cnt_reg + CNT_ONE;
        if (hold_w) begin
          rs_next = SWWD_RS_ASSERT;
        end else if (rs_done_w) begin
          rs_next = SWWD_RS_RUN;
        end
      end
      SWWD_RS_RUN: begin
        if (hold_w) begin
          rs_next = SWWD_RS_ASSERT;
        end
      end
      default: begin
        rs_next = SWWD_RS_ASSERT;
      end
    endcase
  end

  // Watchdog window
  always_comb begin
    wd_next = wd_reg;
    wd_cnt_next = wd_cnt_reg + CNT_ONE;
    case (wd_reg)
      SWWD_WD_IDLE: begin
        wd_cnt_next = CNT_ZERO;
        if (en_w) begin
          wd_next = SWWD_WD_WINDOW;
        end
      end
      SWWD_WD_WINDOW: begin
        if (edge_w) begin
          wd_cnt_next = CNT_ZERO;
          wd_next = early_w ? SWWD_WD_FAULT : SWWD_WD_WINDOW;
        end else if (late_w) begin
          wd_cnt_next = CNT_ZERO;
          wd_next = SWWD_WD_FAULT;
        end
      end
      SWWD_WD_FAULT: begin
        if (wd_done_w) begin
          wd_cnt_next = CNT_ZERO;
          wd_next = SWWD_WD_WINDOW;
        end
      end
      default: begin
        wd_next = SWWD_WD_IDLE;
      end
    endcase
    if (!run_w || !en_w || (rs_reg != SWWD_RS_RUN)) begin
      wd_next = SWWD_WD_IDLE;
      wd_cnt_next = CNT_ZERO;
    end
  end

  wire wd_fault_next_w = (wd_next == SWWD_WD_FAULT);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rs_reg <= SWWD_RS_ASSERT;
      wd_reg <= SWWD_WD_IDLE;
      rs_cnt_reg <= CNT_ZERO;
      wd_cnt_reg <= CNT_ZERO;
      reset_n <= LEVEL_RST;
      reset_oe <= OE_RST;
      watchdog_fault_n <= FAULT_LEVEL_RST;
      watchdog_fault_oe <= FAULT_OE_RST;
    end else begin
      rs_reg <= rs_next;
      wd_reg <= wd_next;
      rs_cnt_reg <= rs_cnt_next;
      wd_cnt_reg <= wd_cnt_next;
      reset_n <= run_w;
      reset_oe <= ~run_w;
      watchdog_fault_n <= ~wd_fault_next_w;
      watchdog_fault_oe <= wd_fault_next_w;
    end
  end

  property p_uv_reset;
    @(posedge clk) disable iff (sys_rst)
    sync2_reg.undervoltage_in |=> !reset_n && reset_oe;
  endproperty
  a_uv_reset: assert property (p_uv_reset)
    else $error("reset not driven on undervoltage");

  property p_release;
    @(posedge clk) disable iff (sys_rst)
    $rose(reset_n) |-> $past(rs_reg) == SWWD_RS_DELAY
      && $past(rs_cnt_reg) == RST_DELAY_CYC - CNT_ONE;
  endproperty
  a_release: assert property (p_release)
    else $error("reset released before delay completed");

  property p_release_good;
    @(posedge clk) disable iff (sys_rst)
    $rose(reset_n) |-> !$past(hold_w) ##0 !$past(hold_w, 2);
  endproperty
  a_release_good: assert property (p_release_good)
    else $error("reset released while supply not good");

  property p_disable;
    @(posedge clk) disable iff (sys_rst)
    !en_w |=> watchdog_fault_n && wd_reg == SWWD_WD_IDLE;
  endproperty
  a_disable: assert property (p_disable)
    else $error("watchdog active while disabled");

  property p_ignore;
    @(posedge clk) disable iff (sys_rst)
    edge_w && wd_reg == SWWD_WD_FAULT && !wd_done_w
      |=> wd_reg != SWWD_WD_WINDOW;
  endproperty
  a_ignore: assert property (p_ignore)
    else $error("service edge accepted during fault");

  property p_late;
    @(posedge clk) disable iff (sys_rst)
    wd_reg == SWWD_WD_WINDOW && late_w && !edge_w && en_w && !hold_w
      |=> !watchdog_fault_n ##0 watchdog_fault_oe;
  endproperty
  a_late: assert property (p_late)
    else $error("missing service did not fault");

  property p_fault_len;
    @(posedge clk) disable iff (sys_rst)
    $rose(watchdog_fault_n) |-> $past(wd_done_w) || $past(hold_w)
      || !$past(en_w) || !$past(reset_n);
  endproperty
  a_fault_len: assert property (p_fault_len)
    else $error("fault released before reset delay");

  property p_fault_reset;
    @(posedge clk) disable iff (sys_rst)
    !watchdog_fault_n |-> reset_n;
  endproperty
  a_fault_reset: assert property (p_fault_reset)
    else $error("fault asserted while reset low");

  property p_mr;
    @(posedge clk) disable iff (sys_rst)
    !sync2_reg.manual_reset_n |=> !reset_n ##1 !reset_n;
  endproperty
  a_mr: assert property (p_mr)
    else $error("manual reset did not hold reset");

  property p_early;
    @(posedge clk) disable iff (sys_rst)
    wd_reg == SWWD_WD_WINDOW && edge_w && en_w && !hold_w
      |=> (watchdog_fault_n == !$past(early_w)) && wd_cnt_reg == CNT_ZERO;
  endproperty
  a_early: assert property (p_early)
    else $error("service edge misjudged");

  c_release: cover property (@(posedge clk) disable iff (sys_rst)
    $rose(reset_n));
  c_late: cover property (@(posedge clk) disable iff (sys_rst)
    $fell(watchdog_fault_n) && !$past(edge_w));
  c_early: cover property (@(posedge clk) disable iff (sys_rst)
    wd_reg == SWWD_WD_WINDOW && edge_w && early_w);
  c_valid: cover property (@(posedge clk) disable iff (sys_rst)
    wd_reg == SWWD_WD_WINDOW && edge_w && !early_w);

endmodule : swwd_top

// [design/swwd_pkg.sv]
package swwd_pkg;

  // Clock and timebase
  localparam longint unsigned CLK_PERIOD_PS = 4000;
  localparam longint unsigned PS_PER_US = 1000000;
  localparam int unsigned CNT_W = 32;

  // Times in microseconds
  localparam longint unsigned RST_DELAY_US = 200;
  localparam longint unsigned WIN0_LOWER_US = 1000;
  localparam longint unsigned WIN0_UPPER_US = 10000;
  localparam longint unsigned WIN1_LOWER_US = 10000;
  localparam longint unsigned WIN1_UPPER_US = 100000;

  // Cycle counts: lower bounds round up, upper bounds and delay round down
  localparam logic [CNT_W-1:0] RST_DELAY_CYC =
    CNT_W'(RST_DELAY_US * PS_PER_US / CLK_PERIOD_PS);
  localparam logic [CNT_W-1:0] WIN0_LOWER_CYC =
    CNT_W'((WIN0_LOWER_US * PS_PER_US + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [CNT_W-1:0] WIN0_UPPER_CYC =
    CNT_W'(WIN0_UPPER_US * PS_PER_US / CLK_PERIOD_PS);
  localparam logic [CNT_W-1:0] WIN1_LOWER_CYC =
    CNT_W'((WIN1_LOWER_US * PS_PER_US + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [CNT_W-1:0] WIN1_UPPER_CYC =
    CNT_W'(WIN1_UPPER_US * PS_PER_US / CLK_PERIOD_PS);
  localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 32'h0000_0001;

  // Reset supervisor states
  typedef enum logic [1:0] {
    SWWD_RS_ASSERT = 2'h0,
    SWWD_RS_DELAY = 2'h1,
    SWWD_RS_RUN = 2'h3
  } swwd_rst_e;

  // Watchdog states
  typedef enum logic [1:0] {
    SWWD_WD_IDLE = 2'h0,
    SWWD_WD_WINDOW = 2'h1,
    SWWD_WD_FAULT = 2'h3
  } swwd_wd_e;

  // Input pins of the supervisor
  typedef struct packed {
    logic undervoltage_in;
    logic manual_reset_n;
    logic watchdog_enable_in;
    logic watchdog_service_in;
    logic timeout_select_in;
  } swwd_pins_s;

  // Values after reset
  localparam swwd_pins_s PINS_RST = 5'h12;
  localparam logic LEVEL_RST = 1'h0;
  localparam logic FAULT_LEVEL_RST = 1'h1;
  localparam logic OE_RST = 1'h1;
  localparam logic FAULT_OE_RST = 1'h0;

endpackage : swwd_pkg

// [bench/swwd_host.sv]
`timescale 1ns/1ps
module swwd_host (
  input wire logic clk,
  input wire logic go,
  input wire logic [7:0] period,
  output logic svc
);
  logic [7:0] cnt_reg = 8'h00;
  always @(posedge clk) begin
    if (!go || cnt_reg == period - 8'h01) begin
      cnt_reg <= #1 8'h00;
    end else begin
      cnt_reg <= #1 cnt_reg + 8'h01;
    end
  end
  assign svc = !(go && cnt_reg >= period - 8'h04);
endmodule : swwd_host

// [bench/testbench.sv]
`timescale 1ns/1ps
module testbench;
  import swwd_pkg::*;
  localparam int RD = 20;
  localparam int LO[2] = '{10, 20};
  localparam int UP[2] = '{40, 80};
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  logic uv = 1'h0, mr = 1'h1, en = 1'h0, sel = 1'h0, go = 1'h0, svc;
  logic [7:0] period = 8'h10;
  swwd_pins_s pins;
  logic reset_n, reset_oe, watchdog_fault_n, watchdog_fault_oe;
  logic rst_w, flt_w;
  int fails = 0, comparisons = 0, n = 0, lowc = 0, base;
  assign pins = {uv, mr, en, svc, sel};
  assign rst_w = reset_oe ? 1'h0 : 1'h1;
  assign flt_w = watchdog_fault_oe ? 1'h0 : 1'h1;
  always #2 clk = ~clk;
  always @(negedge clk) if (flt_w !== 1'h1) lowc++;
  swwd_top #(.RST_DELAY_CYC(32'h14), .WIN0_LOWER_CYC(32'h0A),
    .WIN0_UPPER_CYC(32'h28), .WIN1_LOWER_CYC(32'h14),
    .WIN1_UPPER_CYC(32'h50)) dut (.clk(clk), .sys_rst(sys_rst),
    .pins(pins), .reset_n(reset_n), .reset_oe(reset_oe),
    .watchdog_fault_n(watchdog_fault_n),
    .watchdog_fault_oe(watchdog_fault_oe));
  swwd_host host (.clk(clk), .go(go), .period(period), .svc(svc));
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic close_out();
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out
  task automatic hold(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask : hold
  // Cycles until a wire shows lvl, bounded
  task automatic wait_w(input bit f, input logic lvl, input int lim);
    n = 0;
    while ((f ? flt_w : rst_w) !== lvl) begin
      hold(1);
      n++;
      if (n > lim) begin
        fails++;
        close_out();
      end
    end
  endtask : wait_w
  function automatic logic [31:0] in_rng(int v, int lo, int hi);
    return {31'h0, v >= lo && v <= hi};
  endfunction : in_rng
  task automatic restart();
    go = 1'h0;
    mr = 1'h0;
    hold(4);
    mr = 1'h1;
    wait_w(0, 1'h1, RD + 8);
  endtask : restart
  initial begin
    void'($urandom(2552));
    hold(20);
    sys_rst = 1'h0;
    wait_w(0, 1'h1, RD + 10);
    cmp(in_rng(n, RD, RD + 5), 32'h1);
    cmp({31'h0, reset_n}, 32'h1);
    $display("test power_on done");
    for (int c = 0; c < 2; c++) begin
      hold(1 + $urandom_range(4));
      if (c == 0) uv = 1'h1;
      else mr = 1'h0;
      wait_w(0, 1'h0, 5);
      cmp({31'h0, reset_n}, 32'h0);
      cmp({31'h0, flt_w}, 32'h1);
      hold(3);
      uv = 1'h0;
      mr = 1'h1;
      hold(RD);
      cmp({31'h0, rst_w}, 32'h0);
      wait_w(0, 1'h1, 8);
      $display("test supply_cause %0d done", c);
    end
    en = 1'h1;
    for (int s = 0; s < 2; s++) begin
      sel = s[0];
      restart();
      wait_w(1, 1'h0, UP[s] + 8);
      cmp(in_rng(n, UP[s] - 2, UP[s] + 4), 32'h1);
      cmp({31'h0, watchdog_fault_n}, 32'h0);
      cmp({31'h0, rst_w}, 32'h1);
      wait_w(1, 1'h1, RD + 4);
      cmp(n, RD);
      $display("test timeout set %0d done", s);
    end
    // Fault cut short by a manual reset
    wait_w(1, 1'h0, UP[1] + 8);
    mr = 1'h0;
    hold(4);
    cmp({31'h0, flt_w}, 32'h1);
    cmp({31'h0, watchdog_fault_n}, 32'h1);
    cmp({31'h0, rst_w}, 32'h0);
    $display("test fault_on_reset done");
    sel = 1'h0;
    for (int k = 0; k < 3; k++) begin
      period = 8'(LO[0] + 5 + $urandom_range(UP[0] - LO[0] - 10));
      restart();
      go = 1'h1;
      base = lowc;
      hold(6 * period);
      cmp(lowc - base, 0);
      $display("test service period %0d done", period);
    end
    go = 1'h0;
    period = 8'h06;
    hold(1);
    go = 1'h1;
    wait_w(1, 1'h0, 20);
    cmp(in_rng(n, 1, 20), 32'h1);
    hold(2);
    en = 1'h0;
    hold(4);
    cmp({31'h0, flt_w}, 32'h1);
    base = lowc;
    hold(3 * UP[1]);
    cmp(lowc - base, 0);
    $display("test early_edge and disable done");
    close_out();
  end
endmodule : testbench
